//--- include/osc_ctl_pkg.sv
// shared constants for the oscillator status, enable and tuning block
package osc_ctl_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses, one 32-bit word each)
    // ------------------------------------------------------------------
    localparam int          ADDR_W            = 8;
    localparam logic [7:0]  OFS_READY_STATUS  = 8'h00;
    localparam logic [7:0]  OFS_MANUAL_ENABLE = 8'h04;
    localparam logic [7:0]  OFS_FREQ_SELECT   = 8'h08;
    localparam logic [7:0]  OFS_TRIM          = 8'h0c;
    localparam logic [7:0]  OFS_SWITCH_CTRL   = 8'h10;

    // ------------------------------------------------------------------
    // oscillator indices; status and enable share bits 7..2
    // ------------------------------------------------------------------
    localparam int NUM_OSC      = 6;
    localparam int OSC_EXT      = 5;
    localparam int OSC_FAST_INT = 4;
    localparam int OSC_MED_INT  = 3;
    localparam int OSC_SLOW_INT = 2;
    localparam int OSC_SEC      = 1;
    localparam int OSC_FAST_RC  = 0;
    localparam int OSC_LSB      = 2;
    localparam int PLL_READY_BIT = 0;

    // ------------------------------------------------------------------
    // field layouts
    // ------------------------------------------------------------------
    localparam int FREQ_W  = 3;
    localparam int TRIM_W  = 6;
    localparam int HOLD_BIT      = 7;
    localparam int SEC_PWR_BIT   = 6;
    localparam int HELD_BIT      = 3;

    // ------------------------------------------------------------------
    // reset values and fuse decode
    // ------------------------------------------------------------------
    localparam logic [NUM_OSC-1:0] ENABLE_RESET    = 6'h00;
    localparam logic [TRIM_W-1:0]  TRIM_RESET      = 6'h00;
    localparam logic [2:0]         FUSE_FAST_1MHZ  = 3'h6;
    localparam logic [2:0]         FUSE_FAST_32MHZ = 3'h0;
    localparam logic [2:0]         FREQ_4MHZ       = 3'h2;
    localparam logic [2:0]         FREQ_32MHZ      = 3'h6;
    localparam logic [2:0]         FREQ_RESERVED   = 3'h7;
    localparam logic [2:0]         FREQ_OTHER_RST  = 3'h2;

    // nominal frequency in MHz for codes 0..6; code 7 reads as 0
    localparam logic [5:0] FREQ_MHZ [8] = '{6'd1, 6'd2, 6'd4, 6'd8,
                                            6'd12, 6'd16, 6'd32, 6'd0};
endpackage

//--- logic/osc_status_ctl.sv
// oscillator ready status, manual enables, fast oscillator frequency and trim
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ps

// Overview of operation
// R01 - oscillator ready flag only when usable
// R02 - pll ready needs enable, source, lock
// R03 - status bit 1 reads zero
// R04 - external force-on keeps it in fuse mode
// R05 - fast internal force-on at selected frequency
// R06 - medium and fast-rc force-on run unconditionally
// R07 - slow internal force-on keeps 31 kHz running
// R08 - secondary force-on uses power select
// R09 - frequency codes 0-6 nominal, 7 reserved
// R10 - frequency reset value from reset fuse
// R11 - trim is two's complement around centre
// R12 - trim zero is centre, the default
// R13 - trim bits 7-6 read zero
// R14 - hold pauses switch when new ready
// R15 - ready flags synchronised before reading
module osc_status_ctl
    import osc_ctl_pkg::*;
(
    input  wire logic               sys_clk_i,
    input  wire logic               rst_i,
    // apb slave
    input  wire logic [ADDR_W-1:0]  paddr_i,
    input  wire logic               psel_i,
    input  wire logic               penable_i,
    input  wire logic               pwrite_i,
    input  wire logic [31:0]        pwdata_i,
    output logic      [31:0]        prdata_o,
    output logic                    pready_o,
    output logic                    pslverr_o,
    // fuses, static while running
    input  wire logic [2:0]         reset_clock_source_fuse_i,
    input  wire logic [2:0]         external_osc_mode_fuse_i,
    // oscillator side
    input  wire logic [NUM_OSC-1:0] osc_stable_raw_i,
    input  wire logic               pll_lock_raw_i,
    input  wire logic               pll_enable_i,
    input  wire logic               pll_src_is_ext_i,
    input  wire logic [NUM_OSC-1:0] module_request_i,
    output logic      [NUM_OSC-1:0] osc_run_o,
    output logic      [2:0]         external_osc_mode_o,
    output logic      [FREQ_W-1:0]  fast_internal_freq_select_o,
    output logic      [5:0]         fast_internal_freq_mhz_o,
    output logic      [TRIM_W-1:0]  fast_internal_trim_o,
    output logic                    secondary_osc_power_select_o,
    // clock switch sequencing
    input  wire logic               switch_pending_i,
    input  wire logic [2:0]         new_osc_index_i,
    output logic                    switch_proceed_o,
    output logic                    switch_held_o
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [NUM_OSC-1:0] force_on_reg;
    logic [FREQ_W-1:0]  freq_reg;
    logic [TRIM_W-1:0]  trim_reg;
    logic               hold_reg;
    logic               sec_pwr_reg;
    logic [2:0]         ext_mode_reg;
    logic [31:0]        rdata_reg;
    logic               slverr_reg;
    logic [NUM_OSC-1:0] run_reg;
    logic [5:0]         mhz_reg;
    logic               proceed_reg;
    logic               held_reg;

    logic [NUM_OSC:0]   sync_out;
    logic [NUM_OSC-1:0] osc_stable;
    logic               pll_locked;
    logic [NUM_OSC-1:0] osc_ready;
    logic               pll_ready;
    logic [7:0]         status_byte;
    logic               new_ready;
    logic               addr_hit;
    logic               setup_phase;
    logic               wr_access;
    logic [FREQ_W-1:0]  freq_wr;

    // ------------------------------------------------------------------
    // ready synchronisation
    // ------------------------------------------------------------------
    // stability and lock come from analog domains, so every flag crosses
    ready_sync #(
        .WIDTH (NUM_OSC + 1)
    ) u_ready_sync (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .async_i   ({pll_lock_raw_i, osc_stable_raw_i}),
        .stable_o  (sync_out)
    ); // R15

    assign osc_stable = sync_out[NUM_OSC-1:0];
    assign pll_locked = sync_out[NUM_OSC];

    // a source is usable only while it is running and has settled
    assign osc_ready = osc_stable & run_reg; // R01
    assign pll_ready = pll_enable_i & pll_locked
                     & (pll_src_is_ext_i ? osc_ready[OSC_EXT]
                                         : osc_ready[OSC_FAST_INT]); // R02

    assign status_byte = {osc_ready, 1'b0, pll_ready}; // R01 R02 R03

    // ------------------------------------------------------------------
    // run requests
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            run_reg <= '0;
        end
        else
        begin
            // each source runs when forced or when a module asks for it
            run_reg <= force_on_reg | module_request_i; // R04 R05 R06 R07 R08
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            ext_mode_reg <= 3'h0;
        end
        else
        begin
            ext_mode_reg <= external_osc_mode_fuse_i; // R04
        end
    end

    assign osc_run_o                    = run_reg;
    assign external_osc_mode_o          = ext_mode_reg;
    assign secondary_osc_power_select_o = sec_pwr_reg; // R08

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    always_comb
    begin
        unique case (paddr_i)
            OFS_READY_STATUS,
            OFS_MANUAL_ENABLE,
            OFS_FREQ_SELECT,
            OFS_TRIM,
            OFS_SWITCH_CTRL: addr_hit = 1'b1;
            default:         addr_hit = 1'b0;
        endcase
    end

    assign setup_phase = psel_i & ~penable_i;
    assign wr_access   = psel_i & penable_i & pwrite_i & addr_hit;
    assign freq_wr     = pwdata_i[FREQ_W-1:0];

    // ------------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            force_on_reg <= ENABLE_RESET;
        end
        else if (wr_access && paddr_i == OFS_MANUAL_ENABLE)
        begin
            force_on_reg <= pwdata_i[OSC_LSB +: NUM_OSC];
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            // synchronous reset, so sampling the static fuse here is safe
            unique case (reset_clock_source_fuse_i)
                FUSE_FAST_1MHZ:  freq_reg <= FREQ_4MHZ; // R10
                FUSE_FAST_32MHZ: freq_reg <= FREQ_32MHZ; // R10
                default:         freq_reg <= FREQ_OTHER_RST;
            endcase
        end
        else if (wr_access && paddr_i == OFS_FREQ_SELECT && freq_wr != FREQ_RESERVED)
        begin
            // a reserved code is dropped so the oscillator never sees it
            freq_reg <= freq_wr; // R09
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            trim_reg <= TRIM_RESET; // R12
        end
        else if (wr_access && paddr_i == OFS_TRIM)
        begin
            trim_reg <= pwdata_i[TRIM_W-1:0]; // R11
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            hold_reg    <= 1'b0;
            sec_pwr_reg <= 1'b0;
        end
        else if (wr_access && paddr_i == OFS_SWITCH_CTRL)
        begin
            hold_reg    <= pwdata_i[HOLD_BIT];
            sec_pwr_reg <= pwdata_i[SEC_PWR_BIT];
        end
    end

    // frequency decode is registered so the table lookup stays off the pins
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            mhz_reg <= 6'h00;
        end
        else
        begin
            mhz_reg <= FREQ_MHZ[freq_reg]; // R09
        end
    end

    assign fast_internal_freq_select_o = freq_reg; // R05
    assign fast_internal_freq_mhz_o    = mhz_reg;
    assign fast_internal_trim_o        = trim_reg; // R11

    // ------------------------------------------------------------------
    // clock switch hold
    // ------------------------------------------------------------------
    assign new_ready = (new_osc_index_i < 3'(NUM_OSC)) ? osc_ready[new_osc_index_i] : 1'b0;

    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            proceed_reg <= 1'b0;
            held_reg    <= 1'b0;
        end
        else
        begin
            proceed_reg <= switch_pending_i & new_ready & ~hold_reg; // R14
            held_reg    <= switch_pending_i & new_ready & hold_reg; // R14
        end
    end

    assign switch_proceed_o = proceed_reg;
    assign switch_held_o    = held_reg;

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    // captured in setup so the access phase answers at once with no wait
    always_ff @(posedge sys_clk_i)
    begin
        if (rst_i)
        begin
            rdata_reg  <= 32'h0000_0000;
            slverr_reg <= 1'b0;
        end
        else if (setup_phase)
        begin
            slverr_reg <= ~addr_hit;
            unique case (paddr_i)
                OFS_READY_STATUS:  rdata_reg <= {24'h00_0000, status_byte};
                OFS_MANUAL_ENABLE: rdata_reg <= {24'h00_0000, force_on_reg, 2'b00};
                OFS_FREQ_SELECT:   rdata_reg <= {29'h0000_0000, freq_reg};
                OFS_TRIM:          rdata_reg <= {26'h000_0000, trim_reg}; // R13
                OFS_SWITCH_CTRL:   rdata_reg <= {24'h00_0000, hold_reg, sec_pwr_reg,
                                                 1'b0, 1'b0, held_reg, 3'b000};
                default:           rdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    assign prdata_o  = rdata_reg;
    assign pready_o  = 1'b1;
    assign pslverr_o = slverr_reg & psel_i & penable_i;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_ready_needs_run: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R01
        !run_reg[OSC_MED_INT] |-> !status_byte[OSC_LSB + OSC_MED_INT])
        else $error("ready flag set while source not running");

    a_ready_tracks_stable: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R01
        (osc_stable[OSC_EXT] && run_reg[OSC_EXT]) |-> status_byte[7])
        else $error("external ready flag missing while usable");

    a_pll_ready_cause: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R02
        status_byte[PLL_READY_BIT] |-> (pll_enable_i && pll_locked))
        else $error("pll ready without enable and lock");

    a_status_gap_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R03
        (setup_phase && paddr_i == OFS_READY_STATUS) |=> rdata_reg[1] == 1'b0)
        else $error("unused status bit read nonzero");

    a_force_runs: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R07
        force_on_reg[OSC_SLOW_INT] ##1 force_on_reg[OSC_SLOW_INT]
        |-> run_reg[OSC_SLOW_INT])
        else $error("forced slow oscillator not running");

    a_rc_force_runs: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R06
        $rose(force_on_reg[OSC_FAST_RC]) |=> run_reg[OSC_FAST_RC])
        else $error("forced fast rc oscillator not running");

    a_freq_no_reserved: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R09
        freq_reg != FREQ_RESERVED)
        else $error("frequency field holds reserved code");

    a_freq_fuse_reset: assert property (@(posedge sys_clk_i) // R10
        (rst_i && reset_clock_source_fuse_i == FUSE_FAST_32MHZ) |=> freq_reg == FREQ_32MHZ)
        else $error("frequency reset value wrong for 32 MHz fuse");

    a_trim_write: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R11
        (wr_access && paddr_i == OFS_TRIM) |=> trim_reg == $past(pwdata_i[TRIM_W-1:0]))
        else $error("trim write not stored");

    a_trim_default: assert property (@(posedge sys_clk_i) // R12
        rst_i |=> trim_reg == TRIM_RESET)
        else $error("trim not centred after reset");

    a_trim_upper_zero: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R13
        (setup_phase && paddr_i == OFS_TRIM) |=> rdata_reg[7:6] == 2'b00)
        else $error("trim upper bits read nonzero");

    a_hold_blocks: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R14
        (switch_pending_i && new_ready && hold_reg) |=> (!switch_proceed_o && switch_held_o))
        else $error("switch proceeded while held");

    a_switch_go: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R14
        (switch_pending_i && new_ready && !hold_reg) |=> switch_proceed_o)
        else $error("switch did not proceed when ready");

    a_sync_latency: assert property (@(posedge sys_clk_i) disable iff (rst_i) // R15
        osc_stable_raw_i[OSC_SEC] [*5] |-> osc_stable[OSC_SEC])
        else $error("stable level not passed through synchroniser");

    c_pll_ready: cover property (@(posedge sys_clk_i) disable iff (rst_i)
        $rose(pll_ready));
    c_switch_held: cover property (@(posedge sys_clk_i) disable iff (rst_i)
        $rose(switch_held_o));
    c_reserved_write: cover property (@(posedge sys_clk_i) disable iff (rst_i)
        wr_access && paddr_i == OFS_FREQ_SELECT && freq_wr == FREQ_RESERVED);
    c_bad_address: cover property (@(posedge sys_clk_i) disable iff (rst_i)
        pslverr_o);

endmodule

//--- logic/ready_sync.sv
// three-stage synchroniser with agreement filter for asynchronous ready levels
`timescale 1ns/1ps

module ready_sync
#(
    parameter int WIDTH = 7
)
(
    input  wire logic             sys_clk_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] stable_o
);

    // refused at elaboration: a zero-width chain has nothing to carry
    if (WIDTH < 1)
    begin : g_width_check
        $error("ready_sync: WIDTH must be at least 1");
    end

    // ------------------------------------------------------------------
    // per-bit chain
    // ------------------------------------------------------------------
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_bit
        logic meta_reg;
        logic s2_reg;
        logic s3_reg;
        logic out_reg;

        always_ff @(posedge sys_clk_i)
        begin
            if (rst_i)
            begin
                meta_reg <= 1'b0;
                s2_reg   <= 1'b0;
                s3_reg   <= 1'b0;
            end
            else
            begin
                meta_reg <= async_i[i];
                s2_reg   <= meta_reg;
                s3_reg   <= s2_reg;
            end
        end

        // the first stage feeds only the second; the filter looks at 2 and 3
        always_ff @(posedge sys_clk_i)
        begin
            if (rst_i)
            begin
                out_reg <= 1'b0;
            end
            else if (s2_reg == s3_reg)
            begin
                out_reg <= s3_reg;
            end
        end

        assign stable_o[i] = out_reg;
    end

endmodule

//--- tb/oscillator_status_enable_tuning_test.sv
// self-checking testbench for the oscillator status, enable, frequency and trim block
`timescale 1ns/1ps

module oscillator_status_enable_tuning_test
    import osc_ctl_pkg::*;
;
    // ------------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------------
    logic               sys_clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0]         paddr;
    logic [31:0]        pwdata, prdata, rd;
    logic [2:0]         rst_fuse, ext_fuse, ext_mode, new_idx, freq_sel;
    logic [5:0]         raw, mreq, run, freq_mhz, trim;
    logic               lock, pll_en, src_ext, pend, sec_pwr, proceed, held, err;
    int                 n_fail, tests_run, cycles;
    logic [5:0]         mhz_tab [7] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h20};

    osc_status_ctl dut (
        .sys_clk_i(sys_clk), .rst_i(rst), .paddr_i(paddr), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .reset_clock_source_fuse_i(rst_fuse),
        .external_osc_mode_fuse_i(ext_fuse), .osc_stable_raw_i(raw),
        .pll_lock_raw_i(lock), .pll_enable_i(pll_en), .pll_src_is_ext_i(src_ext),
        .module_request_i(mreq), .osc_run_o(run), .external_osc_mode_o(ext_mode),
        .fast_internal_freq_select_o(freq_sel), .fast_internal_freq_mhz_o(freq_mhz),
        .fast_internal_trim_o(trim), .secondary_osc_power_select_o(sec_pwr),
        .switch_pending_i(pend), .new_osc_index_i(new_idx),
        .switch_proceed_o(proceed), .switch_held_o(held)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task results;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // a hung bench must still reach the verdict
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            n_fail = n_fail + 1;
            results();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp)
        begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            n_fail = n_fail + 1;
        end
    endtask

    task wt(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // setup cycle, then access phase held until pready is seen high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // no local limit: only the bench timeout may end this wait
        @(posedge sys_clk);
        while (pready !== 1'b1)
        begin
            @(posedge sys_clk);
        end
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task do_reset(input logic [2:0] f);
        @(posedge sys_clk);
        rst      <= 1'b1;
        rst_fuse <= f;
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task t_reset;
        do_reset(3'h6);
        rd_chk(OFS_FREQ_SELECT, 32'h2);
        rd_chk(OFS_TRIM, 32'h0);
        rd_chk(OFS_MANUAL_ENABLE, 32'h0);
        rd_chk(OFS_READY_STATUS, 32'h0);
        $display("reset test done");
    endtask

    task t_enable;
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b1, OFS_MANUAL_ENABLE, (32'h4 << i) | 32'h3);
            rd_chk(OFS_MANUAL_ENABLE, 32'h4 << i);
            chk(32'(run), 32'h1 << i);
        end
        chk(32'(ext_mode), 32'h5);
        apb(1'b1, OFS_SWITCH_CTRL, 32'h40);
        wt(2);
        chk(32'(sec_pwr), 32'h1);
        apb(1'b1, OFS_MANUAL_ENABLE, 32'h0);
        @(posedge sys_clk);
        mreq <= 6'h2a;
        wt(3);
        chk(32'(run), 32'h2a);
        mreq <= 6'h00;
        $display("enable test done");
    endtask

    task t_ready;
        apb(1'b1, OFS_MANUAL_ENABLE, 32'hfc);
        @(posedge sys_clk);
        raw     <= 6'h3f;
        lock    <= 1'b1;
        pll_en  <= 1'b1;
        src_ext <= 1'b1;
        rd_chk(OFS_READY_STATUS, 32'h0);
        wt(8);
        rd_chk(OFS_READY_STATUS, 32'hfd);
        src_ext <= 1'b0;
        wt(2);
        rd_chk(OFS_READY_STATUS, 32'hfd);
        pll_en <= 1'b0;
        wt(2);
        rd_chk(OFS_READY_STATUS, 32'hfc);
        pll_en  <= 1'b1;
        src_ext <= 1'b1;
        raw     <= 6'h1f;
        wt(8);
        rd_chk(OFS_READY_STATUS, 32'h7c);
        raw  <= 6'h3f;
        lock <= 1'b0;
        wt(8);
        rd_chk(OFS_READY_STATUS, 32'hfc);
        lock <= 1'b1;
        apb(1'b1, OFS_MANUAL_ENABLE, 32'h04);
        wt(8);
        rd_chk(OFS_READY_STATUS, 32'h04);
        mreq <= 6'h20;
        wt(8);
        rd_chk(OFS_READY_STATUS, 32'h85);
        mreq <= 6'h00;
        $display("ready test done");
    endtask

    task t_freq;
        for (int c = 0; c < 7; c++)
        begin
            apb(1'b1, OFS_FREQ_SELECT, 32'(c));
            rd_chk(OFS_FREQ_SELECT, 32'(c));
            chk(32'(freq_sel), 32'(c));
            chk(32'(freq_mhz), 32'(mhz_tab[c]));
        end
        apb(1'b1, OFS_FREQ_SELECT, 32'h7);
        rd_chk(OFS_FREQ_SELECT, 32'h6);
        apb(1'b1, OFS_FREQ_SELECT, 32'hfa);
        rd_chk(OFS_FREQ_SELECT, 32'h2);
        $display("frequency test done");
    endtask

    task t_trim;
        logic [31:0] wr [5];
        logic [31:0] ex [5];
        wr = '{32'hff, 32'h20, 32'h1f, 32'h01, 32'h00};
        ex = '{32'h3f, 32'h20, 32'h1f, 32'h01, 32'h00};
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b1, OFS_TRIM, wr[i]);
            rd_chk(OFS_TRIM, ex[i]);
            chk(32'(trim), ex[i]);
        end
        $display("trim test done");
    endtask

    task t_switch;
        apb(1'b1, OFS_MANUAL_ENABLE, 32'hfc);
        apb(1'b1, OFS_SWITCH_CTRL, 32'h80);
        @(posedge sys_clk);
        pend    <= 1'b1;
        new_idx <= 3'h4;
        wt(8);
        chk({held, proceed}, 32'h2);
        rd_chk(OFS_SWITCH_CTRL, 32'h88);
        apb(1'b1, OFS_SWITCH_CTRL, 32'h00);
        wt(3);
        chk({held, proceed}, 32'h1);
        new_idx <= 3'h6;
        wt(3);
        chk({held, proceed}, 32'h0);
        pend <= 1'b0;
        $display("switch test done");
    endtask

    task t_bus;
        apb(1'b0, 8'h14, 32'h0);
        chk(rd, 32'h0);
        chk(32'(err), 32'h1);
        chk(32'(pready), 32'h1);
        apb(1'b1, 8'h14, 32'hff);
        apb(1'b1, OFS_READY_STATUS, 32'h02);
        rd_chk(OFS_READY_STATUS, 32'hfd);
        $display("bus test done");
    endtask

    task t_mid_reset;
        do_reset(3'h0);
        rd_chk(OFS_FREQ_SELECT, 32'h6);
        rd_chk(OFS_TRIM, 32'h0);
        rd_chk(OFS_READY_STATUS, 32'h0);
        chk(32'(run), 32'h0);
        do_reset(3'h3);
        rd_chk(OFS_FREQ_SELECT, 32'h2);
        $display("second reset test done");
    endtask

    initial
    begin
        n_fail = 0;
        tests_run = 0;
        cycles = 0;
        rst = 1'b1;
        {psel, penable, pwrite, lock, pll_en, src_ext, pend} = '0;
        paddr = 8'h00;
        pwdata = 32'h0;
        rst_fuse = 3'h6;
        ext_fuse = 3'h5;
        new_idx = 3'h0;
        raw = 6'h00;
        mreq = 6'h00;
        t_reset();
        t_enable();
        t_ready();
        t_freq();
        t_trim();
        t_switch();
        t_bus();
        t_mid_reset();
        results();
    end
endmodule
